/* File: logic/ata_access_decode.v */
// host-port register access decode of a parallel ATA device
// assumes the host adapter drives the strobes asynchronously; all pins are
// resynchronised to CLK_SYS before use. software manages the device over Avalon-MM.
//
// Summary of operation
// - answering for device 1 without packet support, device read returns DEV forced one.
// - answering for device 1 with packet support, device read returns 00h.
// - answering for device 1, command write is stored without a command event.
// - answering for device 1, only EXECUTE DEVICE DIAGNOSTICS is executed.
// - answering for device 1, status read drives 00h.
// - strobes with both or neither chip select asserted are ignored.
// - device is selected only when DEV equals its own device number.
// - in sleep, device control write updates SRST only, responds only if one.
// - in sleep, all reads, device control read included, and all other writes except the device reset cases below are ignored.
// - in sleep with device reset, device write updates DEV, device read ignored.
// - in sleep with device reset, command acted on only if selected and DEVICE RESET.
// - in sleep with device reset, status reads are ignored.
// - in sleep, DMARQ is released regardless of register access.
`include "ata_access_regs.vh"

module ata_access_decode (
  input wire CLK_SYS, // system clock, 100 MHz
  input wire RST_N, // asynchronous reset, active low
  input wire CS0_N, // command block chip select pin
  input wire CS1_N, // control block chip select pin
  input wire [2:0] DA, // register address pins
  input wire DIOR_N, // read strobe pin
  input wire DIOW_N, // write strobe pin
  input wire [15:0] DD_IN, // data bus level seen at the pins
  output wire [15:0] DD_OUT, // data bus value driven by the device
  output wire DD_OE_N, // data bus enable, low while driving
  output wire DMARQ_OUT, // dma request value
  output wire DMARQ_OE_N, // dma request enable, low while driving
  input wire [3:0] AVS_ADDRESS, // avalon byte address
  input wire AVS_READ, // avalon read request
  input wire AVS_WRITE, // avalon write request
  input wire [31:0] AVS_WRITEDATA, // avalon write data
  input wire [3:0] AVS_BYTEENABLE, // avalon byte enables
  output wire [31:0] AVS_READDATA, // avalon read data
  output wire AVS_WAITREQUEST // avalon wait request
);

  reg rst_s1_r;
  reg rst_n_r;
  wire rst_n;

  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_n_r;

  // pin synchronisers: first stage feeds only the second
  reg [23:0] pin_s1_r;
  reg [23:0] pin_s2_r;
  wire [23:0] pin_raw;
  assign pin_raw = {DD_IN, ~CS0_N, ~CS1_N, DA, ~DIOR_N, ~DIOW_N, 1'b0};

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 24'h000000;
      pin_s2_r <= 24'h000000;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  wire [15:0] dd_s;
  wire cs0_s;
  wire cs1_s;
  wire [2:0] da_s;
  wire rd_s;
  wire wr_s;
  assign dd_s = pin_s2_r[23:8];
  assign cs0_s = pin_s2_r[7];
  assign cs1_s = pin_s2_r[6];
  assign da_s = pin_s2_r[5:3];
  assign rd_s = pin_s2_r[2];
  assign wr_s = pin_s2_r[1];

  // act on the strobe edge, not its level, so a long write acts only once
  reg wr_d_r;
  wire wr_start;
  assign wr_start = wr_s & ~wr_d_r;

  // software-owned state
  reg [`CTRL_W-1:0] ctrl_r;
  reg [7:0] status_r;
  reg [`EV_W-1:0] event_r;
  reg [`EV_W-1:0] event_nxt;

  // ata register state
  reg [7:0] dev_r;
  reg [7:0] cmd_r;
  reg [7:0] dctl_r;
  reg [7:0] dev_nxt;
  reg [7:0] cmd_nxt;
  reg [7:0] dctl_nxt;

  wire sleep;
  wire dev_num;
  wire packet;
  wire drst_impl;
  assign sleep = ctrl_r[`CTRL_SLEEP];
  assign dev_num = ctrl_r[`CTRL_DEVNUM];
  assign packet = ctrl_r[`CTRL_PACKET];
  assign drst_impl = ctrl_r[`CTRL_DRST_IMPL];

  wire selected;
  assign selected = dev_r[`DEV_BIT] == dev_num;

  // device 0 stands in for an absent device 1 once DEV points at device 1
  wire answer_d1;
  assign answer_d1 = ctrl_r[`CTRL_ANSWER_D1] & ~dev_num & dev_r[`DEV_BIT];

  wire cs_ok;
  assign cs_ok = cs0_s ^ cs1_s;

  wire hit_dctl;
  wire hit_dev;
  wire hit_cmd;
  assign hit_dctl = cs_ok & cs1_s & (da_s == `ADDR_DCTL);
  assign hit_dev = cs_ok & cs0_s & (da_s == `ADDR_DEV);
  assign hit_cmd = cs_ok & cs0_s & (da_s == `ADDR_CMD);

  wire [7:0] wdata;
  assign wdata = dd_s[7:0];

  reg [`EV_W-1:0] ev_set;

  always @* begin
    dev_nxt = dev_r;
    cmd_nxt = cmd_r;
    dctl_nxt = dctl_r;
    ev_set = {`EV_W{1'b0}};
    if (wr_start) begin
      if (sleep) begin
        if (hit_dctl) begin
          dctl_nxt[`SRST_BIT] = wdata[`SRST_BIT];
          ev_set[`EV_SRST] = wdata[`SRST_BIT];
        end
        if (hit_dev && drst_impl) begin
          dev_nxt[`DEV_BIT] = wdata[`DEV_BIT];
        end
        if (hit_cmd && drst_impl && selected && wdata == `CMD_DRST) begin
          cmd_nxt = wdata;
          ev_set[`EV_DRST] = 1'b1;
        end
        // everything else in sleep falls through untouched
      end else begin
        if (hit_dctl) begin
          dctl_nxt = wdata;
          ev_set[`EV_SRST] = wdata[`SRST_BIT];
        end
        if (hit_dev) begin
          dev_nxt = wdata;
        end
        if (hit_cmd) begin
          if (answer_d1) begin
            cmd_nxt = wdata;
            ev_set[`EV_DIAG] = (wdata == `CMD_DIAG);
          end else if (selected) begin
            cmd_nxt = wdata;
            ev_set[`EV_CMD] = 1'b1;
            ev_set[`EV_DIAG] = (wdata == `CMD_DIAG);
            ev_set[`EV_DRST] = (wdata == `CMD_DRST);
          end
        end
      end
    end
  end

  // read drive decision, evaluated while the read strobe stands
  reg rd_drive;
  reg [7:0] rd_val;

  always @* begin
    rd_drive = 1'b0;
    rd_val = 8'h00;
    if (rd_s && !sleep) begin
      if (hit_dev) begin
        if (answer_d1) begin
          rd_drive = 1'b1;
          if (packet) begin
            rd_val = 8'h00;
          end else begin
            rd_val = dev_r;
            rd_val[`DEV_BIT] = 1'b1;
          end
        end else if (selected) begin
          rd_drive = 1'b1;
          rd_val = dev_r;
        end
      end else if (hit_cmd) begin
        if (answer_d1) begin
          // status of absent device reads zero
          rd_drive = 1'b1;
          rd_val = 8'h00;
        end else if (selected) begin
          rd_drive = 1'b1;
          rd_val = status_r;
        end
      end
    end
  end

  reg dmarq_nxt;
  reg dmarq_oe_n_nxt;

  // sleep releases the request pin whatever the host is doing
  always @* begin
    dmarq_nxt = ctrl_r[`CTRL_DMA_REQ];
    dmarq_oe_n_nxt = 1'b0;
    if (sleep) begin
      dmarq_nxt = 1'b0;
      dmarq_oe_n_nxt = 1'b1;
    end
  end

  reg [7:0] dd_out_r;
  reg dd_oe_n_r;
  reg dmarq_oe_n_r;
  reg dmarq_r;

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      wr_d_r <= 1'b0;
      dev_r <= `DEV_RESET;
      cmd_r <= `CMD_RESET;
      dctl_r <= `DCTL_RESET;
      dd_out_r <= 8'h00;
      dd_oe_n_r <= 1'b1;
      dmarq_r <= 1'b0;
      dmarq_oe_n_r <= 1'b1;
    end else begin
      wr_d_r <= wr_s;
      dev_r <= dev_nxt;
      cmd_r <= cmd_nxt;
      dctl_r <= dctl_nxt;
      dd_out_r <= rd_val;
      dd_oe_n_r <= ~rd_drive;
      dmarq_r <= dmarq_nxt;
      dmarq_oe_n_r <= dmarq_oe_n_nxt;
    end
  end

  assign DD_OUT = {8'h00, dd_out_r};
  assign DD_OE_N = dd_oe_n_r;
  assign DMARQ_OUT = dmarq_r;
  assign DMARQ_OE_N = dmarq_oe_n_r;

  // avalon slave: one wait cycle, answer at the second edge of a request
  reg ack_r;
  reg [31:0] rdata_r;
  wire req;
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_r;
  assign AVS_READDATA = rdata_r;

  wire wr_take;
  assign wr_take = AVS_WRITE & ack_r;

  // only byte lane 0 carries register bits; writes with it disabled change nothing
  wire wr_ctrl;
  wire wr_status;
  wire wr_event;
  assign wr_ctrl = wr_take & AVS_BYTEENABLE[0] & (AVS_ADDRESS == `OFS_CTRL);
  assign wr_status = wr_take & AVS_BYTEENABLE[0] & (AVS_ADDRESS == `OFS_STATUS);
  assign wr_event = wr_take & AVS_BYTEENABLE[0] & (AVS_ADDRESS == `OFS_EVENT);

  reg [`CTRL_W-1:0] ctrl_nxt;
  reg [7:0] status_nxt;
  reg [31:0] rdata_nxt;

  always @* begin
    ctrl_nxt = ctrl_r;
    status_nxt = status_r;
    if (wr_ctrl) begin
      ctrl_nxt = AVS_WRITEDATA[`CTRL_W-1:0];
    end
    if (wr_status) begin
      status_nxt = AVS_WRITEDATA[7:0];
    end
  end

  always @* begin
    event_nxt = event_r;
    if (wr_event) begin
      event_nxt = event_r & ~AVS_WRITEDATA[`EV_W-1:0];
    end
    // a new event beats a clear in the same cycle
    event_nxt = event_nxt | ev_set;
  end

  // the word is captured at the request edge, so it stands at the answering edge
  always @* begin
    rdata_nxt = rdata_r;
    if (AVS_READ && !ack_r) begin
      case (AVS_ADDRESS)
        `OFS_CTRL: rdata_nxt = {26'h0, ctrl_r};
        `OFS_STATUS: rdata_nxt = {24'h000000, status_r};
        `OFS_TASK: rdata_nxt = {8'h00, dctl_r, cmd_r, dev_r};
        `OFS_EVENT: rdata_nxt = {28'h0000000, event_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
      ctrl_r <= `CTRL_RESET;
      status_r <= `STATUS_RESET;
      event_r <= {`EV_W{1'b0}};
    end else begin
      ack_r <= req & ~ack_r;
      event_r <= event_nxt;
      ctrl_r <= ctrl_nxt;
      status_r <= status_nxt;
      rdata_r <= rdata_nxt;
    end
  end

endmodule // ata_access_decode

/* File: logic/ata_access_regs.vh */
// constants for the parallel ATA register access decode block
// assumes a 100 MHz system clock and a 32-bit Avalon-MM register port
`ifndef ATA_ACCESS_REGS_VH
`define ATA_ACCESS_REGS_VH

// avalon word offsets (byte addresses)
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_TASK 4'h8
`define OFS_EVENT 4'hc

// control register fields
`define CTRL_SLEEP 0
`define CTRL_DEVNUM 1
`define CTRL_PACKET 2
`define CTRL_DRST_IMPL 3
`define CTRL_ANSWER_D1 4
`define CTRL_DMA_REQ 5
`define CTRL_W 6
`define CTRL_RESET 6'h00

// host-visible status byte reset value
`define STATUS_RESET 8'h00

// task readback fields: device[7:0], command[15:8], control[23:16]
`define TASK_DEV_LSB 0
`define TASK_CMD_LSB 8
`define TASK_DCTL_LSB 16

// event register fields, write one to clear
`define EV_CMD 0
`define EV_DIAG 1
`define EV_SRST 2
`define EV_DRST 3
`define EV_W 4

// ata register fields and codes
`define DEV_BIT 4
`define SRST_BIT 2
`define CMD_DIAG 8'h90
`define CMD_DRST 8'h08
`define ADDR_DCTL 3'h6
`define ADDR_DEV 3'h6
`define ADDR_CMD 3'h7
`define DEV_RESET 8'h00
`define CMD_RESET 8'h00
`define DCTL_RESET 8'h00

`endif

/* File: verif/ata_access_decode_monitor.sv */
// assertions on the pins and register port of the access decode
// assumes it is bound to ata_access_decode
module ata_access_decode_monitor (
  input wire CLK_SYS,
  input wire RST_N,
  input wire CS0_N,
  input wire CS1_N,
  input wire DIOR_N,
  input wire DD_OE_N,
  input wire DMARQ_OUT,
  input wire DMARQ_OE_N,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] ctrl_r;
  wire a0 = !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N)
      ctrl_r <= 6'h0;
    else if (AVS_WRITE && a0 && AVS_BYTEENABLE[0])
      ctrl_r <= AVS_WRITEDATA[5:0];
  end
  chk_both_cs_quiet: assert property ((!CS0_N && !CS1_N) [*6] |-> DD_OE_N)
    else $error("bus driven with both selects");
  chk_no_cs_quiet: assert property ((CS0_N && CS1_N) [*6] |-> DD_OE_N)
    else $error("bus driven with no select");
  chk_no_read_drive: assert property (DIOR_N [*6] |-> DD_OE_N)
    else $error("bus driven without read");
  chk_sleep_read: assert property ((ctrl_r[0] && !DIOR_N) [*6] |-> DD_OE_N)
    else $error("read answered in sleep");
  chk_sleep_dmarq: assert property (ctrl_r[0] && $past(ctrl_r[0], 2) |-> DMARQ_OE_N && !DMARQ_OUT)
    else $error("dma request driven in sleep");
  chk_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest too long");
  chk_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'h0 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_read: assert property (AVS_READ && a0 |-> AVS_READDATA[5:0] == ctrl_r)
    else $error("control readback wrong");
  cover property (!DIOR_N && !DD_OE_N);
  cover property (ctrl_r[0] && !DIOR_N);
  cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule // ata_access_decode_monitor

/* File: verif/ata_access_decode_tb_top.sv */
// self-checking bench for the access decode
// assumes the host model and monitor are compiled first
module ata_access_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 0;
  logic RST_N = 0;
  logic [3:0] AVS_ADDRESS = 0;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic AVS_READ = 0;
  logic AVS_WRITE = 0;
  logic [31:0] AVS_WRITEDATA = 0;
  logic [31:0] q;
  logic [7:0] dv, st, c;
  wire [31:0] AVS_READDATA;
  wire AVS_WAITREQUEST, CS0_N, CS1_N, DIOR_N, DIOW_N, DD_OE_N, DMARQ_OUT, DMARQ_OE_N;
  wire [2:0] DA;
  wire [15:0] DD_IN, DD_OUT;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  ata_access_decode dut (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .CS0_N(CS0_N),
    .CS1_N(CS1_N),
    .DA(DA),
    .DIOR_N(DIOR_N),
    .DIOW_N(DIOW_N),
    .DD_IN(DD_IN),
    .DD_OUT(DD_OUT),
    .DD_OE_N(DD_OE_N),
    .DMARQ_OUT(DMARQ_OUT),
    .DMARQ_OE_N(DMARQ_OE_N),
    .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST)
  );
  ata_host_model host (
    .CLK_SYS(CLK_SYS),
    .DD_OUT(DD_OUT),
    .DD_OE_N(DD_OE_N),
    .DD_IN(DD_IN),
    .CS0_N(CS0_N),
    .CS1_N(CS1_N),
    .DA(DA),
    .DIOR_N(DIOR_N),
    .DIOW_N(DIOW_N)
  );
  initial forever #5 CLK_SYS = ~CLK_SYS;
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_of_test;
    end
  end
  task chk(string nm, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task t;
    $display("test done, mismatches %0d", n_errors);
  endtask
  task av(logic w, logic [3:0] a, logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 0;
    AVS_READ <= 0;
    @(posedge CLK_SYS);
  endtask
  task rg(logic [3:0] a, logic [31:0] m, logic [31:0] e);
    av(0, a, 0);
    chk("reg", q & m, e);
  endtask
  // e holds {not driven, data}; reads only
  task at(logic w, logic [1:0] cs, logic [2:0] a, logic [7:0] d, logic [8:0] e = 9'h100);
    logic [7:0] b;
    logic o;
    host.xfer(w, cs, a, d, 6 + $urandom_range(0, 6), b, o);
    if (!w)
      chk("ata", {23'h0, o, o ? 8'h00 : b}, {23'h0, e});
  endtask
  task dq(logic [1:0] e);
    repeat (3) @(negedge CLK_SYS);
    chk("dmarq", {30'h0, DMARQ_OE_N, DMARQ_OUT}, {30'h0, e});
    @(posedge CLK_SYS);
  endtask
  initial begin
    void'($urandom(1955));
    repeat (6) @(posedge CLK_SYS);
    RST_N <= 1;
    repeat (4) @(posedge CLK_SYS);
    for (int i = 0; i < 5; i++)
      rg(4'(i < 4 ? i * 4 : 2), 32'hffffffff, 0);
    st = 8'($urandom_range(1, 255));
    dv = 8'($urandom) & 8'hef;
    av(1, 4'h4, {24'h0, st});
    at(1, 2'b10, 3'h6, dv);
    at(0, 2'b10, 3'h7, 0, {1'b0, st});
    at(0, 2'b10, 3'h6, 0, {1'b0, dv});
    at(1, 2'b10, 3'h7, 8'h08);
    rg(4'hc, 32'hf, 32'h9);
    av(1, 4'hc, 32'hf);
    at(1, 2'b00, 3'h6, 8'hff);
    at(1, 2'b11, 3'h6, 8'hff);
    rg(4'h8, 32'hff, {24'h0, dv});
    at(0, 2'b00, 3'h7, 0);
    dv = dv | 8'h10;
    at(1, 2'b10, 3'h6, dv);
    at(0, 2'b10, 3'h7, 0);
    t;
    av(1, 4'h0, 32'h10);
    at(0, 2'b10, 3'h6, 0, {1'b0, dv});
    at(0, 2'b10, 3'h7, 0, 9'h0);
    av(1, 4'h0, 32'h14);
    at(0, 2'b10, 3'h6, 0, 9'h0);
    c = 8'($urandom);
    if (c == 8'h90)
      c = 8'h91;
    at(1, 2'b10, 3'h7, c);
    rg(4'h8, 32'hff00, {16'h0, c, 8'h0});
    rg(4'hc, 32'h2, 0);
    at(1, 2'b10, 3'h7, 8'h90);
    rg(4'hc, 32'h2, 32'h2);
    av(1, 4'hc, 32'hf);
    t;
    av(1, 4'h0, 32'h20);
    dq(2'b01);
    av(1, 4'h0, 32'h21);
    dq(2'b10);
    at(0, 2'b10, 3'h7, 0);
    at(0, 2'b01, 3'h6, 0);
    at(1, 2'b01, 3'h6, 8'h02);
    rg(4'hc, 32'h4, 0);
    at(1, 2'b01, 3'h6, 8'h06);
    rg(4'h8, 32'hff0000, 32'h40000);
    rg(4'hc, 32'h4, 32'h4);
    at(1, 2'b10, 3'h6, 8'h00);
    rg(4'h8, 32'hff, {24'h0, dv});
    t;
    av(1, 4'h0, 32'h29);
    at(1, 2'b10, 3'h6, ~dv & 8'hef);
    dv = dv & 8'hef;
    rg(4'h8, 32'hff, {24'h0, dv});
    at(0, 2'b10, 3'h6, 0);
    at(1, 2'b10, 3'h7, 8'h08);
    rg(4'hc, 32'h8, 32'h8);
    av(1, 4'hc, 32'hf);
    at(1, 2'b10, 3'h7, 8'h90);
    rg(4'hc, 32'ha, 0);
    rg(4'h8, 32'hff00, 32'h800);
    at(1, 2'b10, 3'h6, 8'h10);
    at(1, 2'b10, 3'h7, 8'h08);
    rg(4'hc, 32'h8, 0);
    at(0, 2'b10, 3'h7, 0);
    t;
    end_of_test;
  end
endmodule // ata_access_decode_tb_top
bind ata_access_decode ata_access_decode_monitor mon (
  .CLK_SYS(CLK_SYS),
  .RST_N(RST_N),
  .CS0_N(CS0_N),
  .CS1_N(CS1_N),
  .DIOR_N(DIOR_N),
  .DD_OE_N(DD_OE_N),
  .DMARQ_OUT(DMARQ_OUT),
  .DMARQ_OE_N(DMARQ_OE_N),
  .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST)
);

/* File: verif/ata_host_model.sv */
// host adapter model: runs register cycles on the device pins
// assumes the device shares CLK_SYS; the bench calls xfer
module ata_host_model (
  input wire CLK_SYS, // system clock
  input wire [15:0] DD_OUT, // device data
  input wire DD_OE_N, // device drive enable
  output wire [15:0] DD_IN, // bus level
  output logic CS0_N = 1'b1, // command block select
  output logic CS1_N = 1'b1, // control block select
  output logic [2:0] DA = 3'h0, // address
  output logic DIOR_N = 1'b1, // read strobe
  output logic DIOW_N = 1'b1 // write strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] hd = 16'h5a5a;
  // a released bus flips, so a stale copy never passes
  assign DD_IN = !DD_OE_N ? DD_OUT : hd;
  task xfer(logic w, logic [1:0] cs, logic [2:0] a, logic [7:0] d, int hold, output logic [7:0] q, output logic oe);
    {CS1_N, CS0_N} <= cs;
    DA <= a;
    hd <= w ? {8'h00, d} : ~hd;
    repeat (3) @(posedge CLK_SYS);
    DIOW_N <= !w;
    DIOR_N <= w;
    repeat (hold) @(posedge CLK_SYS);
    q = DD_IN[7:0];
    oe = DD_OE_N;
    DIOW_N <= 1'b1;
    DIOR_N <= 1'b1;
    repeat (5) @(posedge CLK_SYS);
    {CS1_N, CS0_N} <= 2'b11;
    hd <= ~hd;
    // let an edge pass so the next cycle never reassigns these in this step
    @(posedge CLK_SYS);
  endtask
endmodule // ata_host_model
